// ### logic/hdlc_status_pkg.sv
// Constants and carrier types for the HDLC link status register bank.
// Assumes one channel per instance; channel base is added by the caller.
package hdlc_status_pkg;

  // Register offsets for channel 1
  localparam logic [11:0] LATCHED_EVENT_OFS  = 12'h10e;
  localparam logic [11:0] EVENT_MASK_OFS     = 12'h10f;
  localparam logic [11:0] CURRENT_STATUS_OFS = 12'h116;

  // Reset values
  localparam logic [7:0] LATCHED_EVENT_RST = 8'h00;
  localparam logic [7:0] EVENT_MASK_RST    = 8'hff;
  localparam logic [7:0] STATUS_PREV_RST   = 8'h00;
  localparam logic [7:0] READ_DATA_RST     = 8'h00;

  // Field positions in the status, latch and mask registers
  localparam int RX_CODE_MSB   = 7;
  localparam int RX_CODE_LSB   = 5;
  localparam int TX_SERVICE    = 4;
  localparam int RX_FILL_MSB   = 3;
  localparam int RX_FILL_LSB   = 2;
  localparam int TX_FILL_MSB   = 1;
  localparam int TX_FILL_LSB   = 0;

  // Edge select bits: bit 1 arms rising edges, bit 0 arms falling edges
  localparam int EDGE_RISE_BIT = 1;
  localparam int EDGE_FALL_BIT = 0;

  // Receive message status codes
  localparam logic [2:0] RX_CODE_IDLE    = 3'h0;
  localparam logic [2:0] RX_CODE_START   = 3'h1;
  localparam logic [2:0] RX_CODE_VALID   = 3'h2;
  localparam logic [2:0] RX_CODE_CRC_ERR = 3'h3;
  localparam logic [2:0] RX_CODE_ABORT   = 3'h4;

  // Receive FIFO fill states
  localparam logic [1:0] RX_FILL_LOW  = 2'h0;
  localparam logic [1:0] RX_FILL_HALF = 2'h1;
  localparam logic [1:0] RX_FILL_FULL = 2'h2;
  localparam logic [1:0] RX_FILL_OVF  = 2'h3;

  // Transmit FIFO fill states
  localparam logic [1:0] TX_FILL_HIGH  = 2'h0;
  localparam logic [1:0] TX_FILL_LOW   = 2'h1;
  localparam logic [1:0] TX_FILL_OVWR  = 2'h2;
  localparam logic [1:0] TX_FILL_UNDER = 2'h3;

  // Conditions reported by the HDLC controllers and FIFOs
  typedef struct packed {
    logic rx_start;
    logic rx_valid;
    logic rx_crc_err;
    logic rx_abort;
    logic tx_msg_done;
    logic rx_fifo_half;
    logic rx_fifo_full;
    logic rx_fifo_ovf;
    logic tx_fifo_half_or_less;
    logic tx_fifo_overwrite;
    logic tx_fifo_underflow;
  } hdlc_cond_t;

  // Current status register layout
  typedef struct packed {
    logic [2:0] rx_message_status_code;
    logic       tx_service;
    logic [1:0] rx_fifo_fill_state;
    logic [1:0] tx_fifo_fill_state;
  } hdlc_status_t;

endpackage

// ### logic/event_edge_latch.sv
// Per-bit edge detect and sticky latch for the status bank.
// Assumes status, write strobe and data all come from the same clock.
`timescale 1ns/1ps
`default_nettype none
module event_edge_latch (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_status,
  input  wire logic [1:0] i_edge_sel,
  input  wire logic       i_clr_wr,
  input  wire logic [7:0] i_clr_data,
  output logic      [7:0] o_latched
);

  logic [7:0] prev_r;
  logic [7:0] prev_nxt;
  logic [7:0] latched_r;
  logic [7:0] latched_nxt;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      logic hit;
      always_comb begin
        hit = (i_edge_sel[hdlc_status_pkg::EDGE_RISE_BIT] & i_status[b] & ~prev_r[b]) |
              (i_edge_sel[hdlc_status_pkg::EDGE_FALL_BIT] & ~i_status[b] & prev_r[b]); // see R13
        prev_nxt[b] = i_status[b];
        // New edge beats a clearing write in the same cycle
        if (hit) begin
          latched_nxt[b] = 1'b1; // see R13
        end else if (i_clr_wr && !i_clr_data[b]) begin
          latched_nxt[b] = 1'b0; // see R14
        end else begin
          latched_nxt[b] = latched_r[b]; // see R14
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prev_r    <= hdlc_status_pkg::STATUS_PREV_RST;
      latched_r <= hdlc_status_pkg::LATCHED_EVENT_RST;
    end else begin
      prev_r    <= prev_nxt;
      latched_r <= latched_nxt;
    end
  end

  assign o_latched = latched_r;

endmodule
`default_nettype wire

// ### logic/hdlc_link_status_reporting.sv
// HDLC link status, latched event and mask registers for one channel.
// Assumes controller conditions are levels on i_clk; port strobes are one cycle.
// How it works
// R1: set tx FIFO mask bits block their events
// R2: rx status in bits 7-5, idle zero
// R3: start of message reads code 001
// R4: good short message or FIFO service flagged
// R5: that condition uses code 010
// R6: CRC failed message reads code 011
// R7: abort sets rx code MSB
// R8: bit 4 high when tx FIFO needs service
// R9: rx fill 00 below half, 01 half+
// R10: rx fill 10 full, 11 overflowed
// R11: tx fill 00 above half, 01 half-
// R12: tx fill 10 overwrite, 11 underflow
// R13: latch on selected status edge
// R14: write 0 clears latched bit until edge
// R15: unmasked latched bit raises interrupt
`timescale 1ns/1ps
`default_nettype none
module hdlc_link_status_reporting (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire hdlc_status_pkg::hdlc_cond_t i_cond,
  input  wire logic [1:0]                  i_edge_sel,
  input  wire logic [11:0]                 i_addr,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire logic [7:0]                  i_wr_data,
  output logic      [7:0]                  o_rd_data,
  output logic                             o_irq
);

  hdlc_status_pkg::hdlc_status_t status;
  logic [7:0]                    latched;
  logic [7:0]                    mask_r;
  logic [7:0]                    mask_nxt;
  logic [7:0]                    rd_data_r;
  logic [7:0]                    rd_data_nxt;
  logic                          wr_latch;
  logic                          wr_mask;

  // Current status encoding, most severe condition first
  always_comb begin
    if (i_cond.rx_abort) begin
      status.rx_message_status_code = hdlc_status_pkg::RX_CODE_ABORT; // see R7
    end else if (i_cond.rx_crc_err) begin
      status.rx_message_status_code = hdlc_status_pkg::RX_CODE_CRC_ERR; // see R6
    end else if (i_cond.rx_valid) begin
      status.rx_message_status_code = hdlc_status_pkg::RX_CODE_VALID; // see R4 see R5
    end else if (i_cond.rx_start) begin
      status.rx_message_status_code = hdlc_status_pkg::RX_CODE_START; // see R3
    end else begin
      status.rx_message_status_code = hdlc_status_pkg::RX_CODE_IDLE; // see R2
    end
    status.tx_service = i_cond.tx_msg_done | i_cond.tx_fifo_half_or_less; // see R8
    if (i_cond.rx_fifo_ovf) begin
      status.rx_fifo_fill_state = hdlc_status_pkg::RX_FILL_OVF; // see R10
    end else if (i_cond.rx_fifo_full) begin
      status.rx_fifo_fill_state = hdlc_status_pkg::RX_FILL_FULL; // see R10
    end else if (i_cond.rx_fifo_half) begin
      status.rx_fifo_fill_state = hdlc_status_pkg::RX_FILL_HALF; // see R9
    end else begin
      status.rx_fifo_fill_state = hdlc_status_pkg::RX_FILL_LOW; // see R9
    end
    if (i_cond.tx_fifo_underflow) begin
      status.tx_fifo_fill_state = hdlc_status_pkg::TX_FILL_UNDER; // see R12
    end else if (i_cond.tx_fifo_overwrite) begin
      status.tx_fifo_fill_state = hdlc_status_pkg::TX_FILL_OVWR; // see R12
    end else if (i_cond.tx_fifo_half_or_less) begin
      status.tx_fifo_fill_state = hdlc_status_pkg::TX_FILL_LOW; // see R11
    end else begin
      status.tx_fifo_fill_state = hdlc_status_pkg::TX_FILL_HIGH; // see R11
    end
  end

  assign wr_latch = i_wr && (i_addr == hdlc_status_pkg::LATCHED_EVENT_OFS);
  assign wr_mask  = i_wr && (i_addr == hdlc_status_pkg::EVENT_MASK_OFS);

  event_edge_latch u_latch (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_status   (status),
    .i_edge_sel (i_edge_sel),
    .i_clr_wr   (wr_latch),
    .i_clr_data (i_wr_data),
    .o_latched  (latched)
  );

  // Register port; unmapped reads return zero
  always_comb begin
    mask_nxt    = wr_mask ? i_wr_data : mask_r;
    rd_data_nxt = rd_data_r;
    if (i_rd) begin
      case (i_addr)
        hdlc_status_pkg::LATCHED_EVENT_OFS:  rd_data_nxt = latched;
        hdlc_status_pkg::EVENT_MASK_OFS:     rd_data_nxt = mask_r;
        hdlc_status_pkg::CURRENT_STATUS_OFS: rd_data_nxt = status;
        default:                             rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mask_r    <= hdlc_status_pkg::EVENT_MASK_RST;
      rd_data_r <= hdlc_status_pkg::READ_DATA_RST;
    end else begin
      mask_r    <= mask_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // Combinational so the interrupt follows the latch without extra delay
  assign o_irq     = |(latched & ~mask_r); // see R15 see R1
  assign o_rd_data = rd_data_r;

endmodule
`default_nettype wire

// ### test/hdlc_link_status_reporting_asserts.sv
// Checker for the HDLC status bank: read map of the status register and the read port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hdlc_link_status_reporting_asserts (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire hdlc_status_pkg::hdlc_cond_t i_cond,
  input  wire logic [1:0]                  i_edge_sel,
  input  wire logic [11:0]                 i_addr,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire logic [7:0]                  i_wr_data,
  input  wire logic [7:0]                  o_rd_data,
  input  wire logic                        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence rd_stat;
    i_rd && i_addr == 12'h116;
  endsequence
  a_rx_start_code: assert property (rd_stat ##0 i_cond[10:7] == 4'h8 |=> o_rd_data[7:5] == 3'h1)
    else $error("start code wrong");
  a_rx_valid_code: assert property (rd_stat ##0 i_cond[9:7] == 3'h4 |=> o_rd_data[7:5] == 3'h2)
    else $error("valid code wrong");
  a_rx_crc_code: assert property (rd_stat ##0 i_cond[8:7] == 2'h2 |=> o_rd_data[7:5] == 3'h3)
    else $error("crc code wrong");
  a_rx_abort_msb: assert property (rd_stat ##0 i_cond.rx_abort |=> o_rd_data[7])
    else $error("abort bit low");
  a_tx_service_bit: assert property (rd_stat |=> o_rd_data[4] == $past(i_cond[6] | i_cond[2]))
    else $error("tx service bit wrong");
  a_rx_ovf_state: assert property (rd_stat ##0 i_cond.rx_fifo_ovf |=> o_rd_data[3:2] == 2'h3)
    else $error("rx overflow state wrong");
  a_tx_under_state: assert property (rd_stat ##0 i_cond[0] |=> o_rd_data[1:0] == 2'h3)
    else $error("tx underflow state wrong");
  a_rd_data_hold: assert property (!i_rd |=> $stable(o_rd_data))
    else $error("read data moved");
  a_unmapped_zero: assert property (i_rd && i_addr == 12'h0ff |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind hdlc_link_status_reporting hdlc_link_status_reporting_asserts u_chk (
  .i_clk      (i_clk),
  .i_sys_rst  (i_sys_rst),
  .i_cond     (i_cond),
  .i_edge_sel (i_edge_sel),
  .i_addr     (i_addr),
  .i_wr       (i_wr),
  .i_rd       (i_rd),
  .i_wr_data  (i_wr_data),
  .o_rd_data  (o_rd_data),
  .o_irq      (o_irq)
);
`default_nettype wire

// ### test/hdlc_link_status_reporting_tb_top.sv
// Self-checking bench for the HDLC status bank against a bench model.
// Assumes design, package and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module hdlc_link_status_reporting_tb_top;
  logic                        i_clk, i_sys_rst, i_wr, i_rd, o_irq;
  hdlc_status_pkg::hdlc_cond_t i_cond;
  logic [1:0]                  i_edge_sel;
  logic [11:0]                 i_addr;
  logic [7:0]                  i_wr_data, o_rd_data, lat_m, msk_m, prv_m, rd_m, ev, s, wd;
  logic [15:0]                 r;
  logic [11:0]                 adr [4] = '{12'h10e, 12'h10f, 12'h116, 12'h0ff};
  int                          n_fail, check_count, k;
  hdlc_link_status_reporting u_hdlc_link_status_reporting (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_cond(i_cond), .i_edge_sel(i_edge_sel), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .o_irq(o_irq));
  function automatic logic [7:0] stat(hdlc_status_pkg::hdlc_cond_t c);
    stat[7:5] = c.rx_abort ? 3'h4 : c.rx_crc_err ? 3'h3 : c.rx_valid ? 3'h2 : {2'h0, c.rx_start};
    stat[4] = c.tx_msg_done | c.tx_fifo_half_or_less;
    stat[3:2] = c.rx_fifo_ovf ? 2'h3 : c.rx_fifo_full ? 2'h2 : {1'b0, c.rx_fifo_half};
    stat[1:0] = c.tx_fifo_underflow ? 2'h3 : c.tx_fifo_overwrite ? 2'h2 : {1'b0, c[2]};
  endfunction
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Model sees pre-edge inputs, as the design does
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      lat_m = 8'h00;
      msk_m = 8'hff;
      prv_m = 8'h00;
      rd_m = 8'h00;
    end else begin
      s = stat(i_cond);
      if (i_rd)
        rd_m = i_addr == 12'h10e ? lat_m : i_addr == 12'h10f ? msk_m : i_addr == 12'h116 ? s : 8'h00;
      ev = (i_edge_sel[1] ? s & ~prv_m : 8'h00) | (i_edge_sel[0] ? ~s & prv_m : 8'h00);
      if (i_wr && i_addr == 12'h10e)
        lat_m = lat_m & i_wr_data;
      lat_m = lat_m | ev;
      if (i_wr && i_addr == 12'h10f)
        msk_m = i_wr_data;
      prv_m = s;
    end
  end
  always @(negedge i_clk) begin
    `CHK("o_irq", |(lat_m & ~msk_m), o_irq)
    `CHK("o_rd_data", rd_m, o_rd_data)
  end
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic put(logic [11:0] a, logic w, logic [7:0] d, logic [10:0] c, logic rd, logic [1:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_wr <= w;
    i_wr_data <= d;
    i_cond <= c;
    i_rd <= rd;
    i_edge_sel <= e;
  endtask
  initial begin
    {i_sys_rst, i_cond, i_edge_sel, i_addr, i_wr, i_rd, i_wr_data} = {1'b1, 35'h0};
    r = 16'h005a;
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    put(12'h10f, 1'b0, 8'h00, 11'h000, 1'b1, 2'h2);
    put(12'h10e, 1'b0, 8'h00, 11'h000, 1'b1, 2'h2);
    $display("Test reset values done");
    for (k = 0; k < 600; k++) begin
      r = lfsr(r);
      wd = r[7:0];
      r = lfsr(r);
      put(adr[r[1:0]], r[2] & r[3], wd, r[15:5], r[4], r[9:8]);
    end
    $display("Test random traffic done");
    // Live conditions across reset: history restarts at zero, mask at all ones
    put(12'h10e, 1'b0, 8'h00, 11'h7ff, 1'b0, 2'h3);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    put(12'h10f, 1'b0, 8'h00, 11'h7ff, 1'b1, 2'h3);
    put(12'h10e, 1'b0, 8'h00, 11'h7ff, 1'b1, 2'h3);
    put(12'h10e, 1'b0, 8'h00, 11'h000, 1'b1, 2'h3);
    $display("Test mid-run reset done");
    put(12'h10f, 1'b1, 8'hfc, 11'h000, 1'b1, 2'h2);
    put(12'h10e, 1'b1, 8'h00, 11'h000, 1'b1, 2'h2);
    put(12'h116, 1'b0, 8'h00, 11'h001, 1'b1, 2'h2);
    put(12'h10e, 1'b0, 8'h00, 11'h001, 1'b1, 2'h2);
    put(12'h10f, 1'b1, 8'hfd, 11'h001, 1'b1, 2'h2);
    put(12'h10e, 1'b1, 8'hfd, 11'h001, 1'b1, 2'h2);
    put(12'h10e, 1'b1, 8'h00, 11'h000, 1'b0, 2'h2);
    put(12'h116, 1'b0, 8'h00, 11'h004, 1'b1, 2'h2);
    put(12'h10e, 1'b0, 8'h00, 11'h004, 1'b1, 2'h2);
    put(12'h10f, 1'b1, 8'hff, 11'h000, 1'b0, 2'h1);
    repeat (2) @(posedge i_clk);
    $display("Test transmit mask done");
    test_done();
  end
endmodule
`default_nettype wire
